// [core/drive_param_regs.svh]
// Offsets, field positions, reset values and codes of the parameter map
// Included by the access checker and by its bench
`ifndef DRIVE_PARAM_REGS_SVH
`define DRIVE_PARAM_REGS_SVH
`define OFS_MODEL     16'h0000
`define OFS_RATING    16'h0001
`define OFS_SUPPLY    16'h0002
`define OFS_FWVER     16'h0003
`define OFS_SPEED     16'h0005
`define OFS_CMDWORD   16'h0006
`define OFS_RAMPUP    16'h0007
`define OFS_RAMPDN    16'h0008
`define OFS_CURRENT   16'h0009
`define OFS_FREQ      16'h000a
`define OFS_VOLTAGE   16'h000b
`define OFS_BUSV      16'h000c
`define OFS_POWER     16'h000d
`define OFS_STATUS    16'h000e
// Arbitrary identity value
`define MODEL_VAL     16'h00a5
`define RATING_VAL    16'h0004
`define SUPPLY_VAL    16'h0001
`define FWVER_VAL     16'h0100
`define SPEED_RST     16'h0000
`define RAMPUP_RST    16'h0032
`define RAMPDN_RST    16'h0032
`define SPEED_MAX     16'h2ee0
`define RAMP_MAX      16'h1770
// Command word fields
`define CW_STOP       0
`define CW_FWD        1
`define CW_REV        2
`define CW_FRST       3
`define CW_ESTOP      4
`define CW_CSRC       6
`define CW_FSRC       8
`define CW_NETERR     15
// Link characters
`define CH_READ       8'h52
`define CH_WRITE      8'h57
`define CH_MONREG     8'h58
`define CH_MONACT     8'h59
`define CH_ACK        8'h06
`define CH_NAK        8'h15
`define ERR_NONE      16'h0000
`define ERR_FUNC      16'h4946
`define ERR_ADDR      16'h4941
`define ERR_VALUE     16'h4944
`define ERR_WMODE     16'h574d
`endif

// [core/drive_param_pkg.sv]
// Types shared by the parameter access checker and its bench
// Assumes the map constants of drive_param_regs.svh
package drive_param_pkg;
  typedef struct packed {
    logic [7:0]  cmd;
    logic [15:0] addr;
    logic [15:0] data;
  } req_t;
  typedef struct packed {
    logic [7:0]  ctrl;
    logic [7:0]  cmd;
    logic [15:0] err;
    logic [15:0] data;
  } rsp_t;
  typedef struct packed {
    logic fwd;
    logic rev;
    logic trip;
    logic accel;
    logic decel;
  } drv_status_t;
  typedef struct packed {
    logic [15:0] current;
    logic [15:0] freq;
    logic [15:0] voltage;
    logic [15:0] busv;
    logic [15:0] power;
  } meas_t;
  typedef enum logic [2:0] {
    V_OK,
    V_FUNC,
    V_ADDR,
    V_WMODE,
    V_VALUE
  } verdict_t;
endpackage

// [core/drive_param_access_checker.sv]
// Parameter access checker: judges one decoded request a cycle and
// answers with an ACK word or a NAK error code.
// Assumes frames are parsed and checksummed upstream, one word a request.
//
// Contract
// - A command other than R, W, X or Y is answered with IF.
// - An address outside the map in an R or W request is answered with bad_location_error and not accessed; X and Y get no address check.
// - A write of an out-of-range value is refused with bad_value_error.
// - A write to a read-only or run-locked word is refused with write_refused_error.
// - Command word bits 0, 1, 2 request stop, forward and reverse.
// - Fault reset fires only on a 0 to 1 change of command bit 3.
// - Command bit 4 requests emergency stop and bit 5 does nothing.
// - Command bits 7:6 report the run/stop command source.
// - Command bits 12:8 report the frequency reference source.
// - Command bit 15 is set once a network error has occurred.
// - The status word flags stop, fwd, rev, trip, accel, decel in 0..5.
// - The version word reads as its hexadecimal release code.
// - Every refusal is a NAK reply carrying a two-character code.
// - Lower-case command letters are answered with IF.
`include "drive_param_regs.svh"
module drive_param_access_checker
  import drive_param_pkg::*;
(
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        nrst,
  // Decoded request
  input  wire logic        reqValid,
  input  wire req_t        req,
  // Reply
  output logic             rspValid,
  output rsp_t             rsp,
  // Drive state
  input  wire drv_status_t drvStatus,
  input  wire meas_t       meas,
  input  wire logic [1:0]  cmdSource,
  input  wire logic [4:0]  freqSource,
  input  wire logic        netErrorEvent,
  // Drive requests
  output logic             stopReq,
  output logic             fwdReq,
  output logic             revReq,
  output logic             estopReq,
  output logic             faultResetPulse,
  output logic [15:0]      speedSetpoint,
  output logic [15:0]      rampUpTime,
  output logic [15:0]      rampDownTime
);

  logic        rspValid_ff;
  rsp_t        rsp_ff;
  logic [4:0]  cmdBits_ff;
  logic        netErr_ff;
  logic        frst_ff;
  logic [15:0] speed_ff;
  logic [15:0] rampUp_ff;
  logic [15:0] rampDn_ff;

  verdict_t    verdict;
  logic        legalCmd;
  logic        isWrite;
  logic        isMon;
  logic        mapHit;
  logic        readOnly;
  logic        running;
  logic        runLock;
  logic        inRange;
  logic [15:0] cmdWord;
  logic [15:0] statusWord;
  logic [15:0] rdWord;
  logic [15:0] nxt_err;
  logic        doWrite;

  assign running = drvStatus.fwd | drvStatus.rev;

  // Live view of the command word
  always_comb
  begin
    cmdWord = 16'h0000;
    cmdWord[`CW_ESTOP:`CW_STOP] = cmdBits_ff;
    cmdWord[`CW_CSRC+1:`CW_CSRC] = cmdSource;
    cmdWord[`CW_FSRC+4:`CW_FSRC] = freqSource;
    cmdWord[`CW_NETERR] = netErr_ff;
  end

  always_comb
  begin
    statusWord = 16'h0000;
    statusWord[0] = ~running;
    statusWord[1] = drvStatus.fwd;
    statusWord[2] = drvStatus.rev;
    statusWord[3] = drvStatus.trip;
    statusWord[4] = drvStatus.accel;
    statusWord[5] = drvStatus.decel;
  end

  // Word read from the map
  always_comb
  begin
    mapHit = 1'b1;
    readOnly = 1'b1;
    rdWord = 16'h0000;
    case (req.addr)
      `OFS_MODEL:   rdWord = `MODEL_VAL;
      `OFS_RATING:  rdWord = `RATING_VAL;
      `OFS_SUPPLY:  rdWord = `SUPPLY_VAL;
      `OFS_FWVER:   rdWord = `FWVER_VAL;
      `OFS_SPEED:
      begin
        rdWord = speed_ff;
        readOnly = 1'b0;
      end
      `OFS_CMDWORD:
      begin
        rdWord = cmdWord;
        readOnly = 1'b0;
      end
      `OFS_RAMPUP:
      begin
        rdWord = rampUp_ff;
        readOnly = 1'b0;
      end
      `OFS_RAMPDN:
      begin
        rdWord = rampDn_ff;
        readOnly = 1'b0;
      end
      `OFS_CURRENT: rdWord = meas.current;
      `OFS_FREQ:    rdWord = meas.freq;
      `OFS_VOLTAGE: rdWord = meas.voltage;
      `OFS_BUSV:    rdWord = meas.busv;
      `OFS_POWER:   rdWord = meas.power;
      `OFS_STATUS:  rdWord = statusWord;
      default:      mapHit = 1'b0;
    endcase
  end

  // Range of each writable word
  always_comb
  begin
    case (req.addr)
      `OFS_SPEED:   inRange = req.data <= `SPEED_MAX;
      `OFS_RAMPUP,
      `OFS_RAMPDN:  inRange = req.data <= `RAMP_MAX;
      `OFS_CMDWORD: inRange = ~(req.data[`CW_FWD] & req.data[`CW_REV]);
      default:      inRange = 1'b1;
    endcase
  end

  // Upper case only; lower case falls through as undefined
  assign legalCmd = (req.cmd == `CH_READ) | (req.cmd == `CH_WRITE) |
                    (req.cmd == `CH_MONREG) | (req.cmd == `CH_MONACT);
  assign isWrite = req.cmd == `CH_WRITE;
  assign isMon = (req.cmd == `CH_MONREG) | (req.cmd == `CH_MONACT);
  assign runLock = running &
                   ((req.addr == `OFS_RAMPUP) | (req.addr == `OFS_RAMPDN));

  // Check order fixes which error is reported
  always_comb
  begin
    if (!legalCmd)
      verdict = V_FUNC;
    else if (isMon)
      verdict = V_OK;
    else if (!mapHit)
      verdict = V_ADDR;
    else if (isWrite && (readOnly || runLock))
      verdict = V_WMODE;
    else if (isWrite && !inRange)
      verdict = V_VALUE;
    else
      verdict = V_OK;
  end

  always_comb
  begin
    case (verdict)
      V_FUNC:  nxt_err = `ERR_FUNC;
      V_ADDR:  nxt_err = `ERR_ADDR;
      V_WMODE: nxt_err = `ERR_WMODE;
      V_VALUE: nxt_err = `ERR_VALUE;
      default: nxt_err = `ERR_NONE;
    endcase
  end

  assign doWrite = reqValid & isWrite & (verdict == V_OK);

  // Reply, one cycle after the request
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      rspValid_ff <= 1'b0;
      rsp_ff <= '0;
    end
    else
    begin
      rspValid_ff <= reqValid;
      if (reqValid)
      begin
        rsp_ff.ctrl <= (nxt_err == `ERR_NONE) ? `CH_ACK : `CH_NAK;
        rsp_ff.cmd <= req.cmd;
        rsp_ff.err <= nxt_err;
        rsp_ff.data <= (nxt_err == `ERR_NONE && !isMon) ? rdWord : 16'h0000;
      end
    end
  end

  // Writable words
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      speed_ff <= `SPEED_RST;
      rampUp_ff <= `RAMPUP_RST;
      rampDn_ff <= `RAMPDN_RST;
    end
    else if (doWrite)
    begin
      if (req.addr == `OFS_SPEED)
        speed_ff <= req.data;
      if (req.addr == `OFS_RAMPUP)
        rampUp_ff <= req.data;
      if (req.addr == `OFS_RAMPDN)
        rampDn_ff <= req.data;
    end
  end

  // Command bits; bit 5 and reported fields are not stored
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
      cmdBits_ff <= 5'h00;
    else if (doWrite && req.addr == `OFS_CMDWORD)
      cmdBits_ff <= req.data[`CW_ESTOP:`CW_STOP];
  end

  // Fault reset on rising bit 3 only
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
      frst_ff <= 1'b0;
    else
      frst_ff <= doWrite && req.addr == `OFS_CMDWORD &&
                 req.data[`CW_FRST] && !cmdBits_ff[`CW_FRST];
  end

  // Sticky network error; a new event beats a clearing write
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
      netErr_ff <= 1'b0;
    else if (netErrorEvent)
      netErr_ff <= 1'b1;
    else if (doWrite && req.addr == `OFS_CMDWORD && !req.data[`CW_NETERR])
      netErr_ff <= 1'b0;
  end

  assign rspValid = rspValid_ff;
  assign rsp = rsp_ff;
  assign stopReq = cmdBits_ff[`CW_STOP];
  assign fwdReq = cmdBits_ff[`CW_FWD];
  assign revReq = cmdBits_ff[`CW_REV];
  assign estopReq = cmdBits_ff[`CW_ESTOP];
  assign faultResetPulse = frst_ff;
  assign speedSetpoint = speed_ff;
  assign rampUpTime = rampUp_ff;
  assign rampDownTime = rampDn_ff;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  sequence s_cmdWrite;
    reqValid && isWrite && req.addr == `OFS_CMDWORD && !running;
  endsequence

  sequence s_nak(logic [15:0] code);
    rspValid && rsp.ctrl == `CH_NAK && rsp.err == code;
  endsequence

  illegal_cmd_a: assert property (
    reqValid && !legalCmd |=> s_nak(`ERR_FUNC))
    else $error("undefined command not answered with IF");

  lower_case_a: assert property (
    reqValid && req.cmd inside {8'h72, 8'h77, 8'h78, 8'h79} |=> s_nak(`ERR_FUNC))
    else $error("lower-case command not answered with IF");

  bad_addr_a: assert property (
    reqValid && legalCmd && !isMon && !mapHit |=> s_nak(`ERR_ADDR))
    else $error("missing address not answered with bad_location_error");

  write_mode_a: assert property (
    reqValid && isWrite && mapHit && readOnly |=> s_nak(`ERR_WMODE))
    else $error("read-only write not answered with write_refused_error");

  bad_value_a: assert property (
    reqValid && isWrite && req.addr == `OFS_SPEED && req.data > `SPEED_MAX
    |=> s_nak(`ERR_VALUE) && $stable(speedSetpoint))
    else $error("out of range speed accepted");

  nak_frame_a: assert property (
    rspValid |-> (rsp.ctrl == `CH_NAK) == (rsp.err != `ERR_NONE))
    else $error("reply control and error code disagree");

  cmd_apply_a: assert property (
    s_cmdWrite ##0 !(req.data[1] && req.data[2]) |=>
    {revReq, fwdReq, stopReq} == $past(req.data[2:0]))
    else $error("command bits not applied");

  fault_edge_a: assert property (
    faultResetPulse |-> $past(cmdBits_ff[`CW_FRST]) == 1'b0 &&
    cmdBits_ff[`CW_FRST] ##1 !faultResetPulse)
    else $error("fault reset without rising bit 3");

  net_error_a: assert property (
    netErrorEvent |=> cmdWord[`CW_NETERR] [*2])
    else $error("network error flag not held");

  version_read_a: assert property (
    reqValid && req.cmd == `CH_READ && req.addr == `OFS_FWVER
    |=> rsp.data == `FWVER_VAL)
    else $error("version word wrong");

  status_read_a: assert property (
    reqValid && req.cmd == `CH_READ && req.addr == `OFS_STATUS
    |=> rsp.data[3:1] == $past({drvStatus.trip, drvStatus.rev, drvStatus.fwd}))
    else $error("status word wrong");

endmodule

// [dv/link_master_model.sv]
// Serial link master model: issues one decoded word request at a time
// Assumes the checker answers each request within a few clocks
module link_master_model
  import drive_param_pkg::*;
(
  // Clock
  input  wire logic mclk,
  // Request side
  output logic      reqValid,
  output req_t      req,
  // Reply side
  input  wire logic rspValid,
  input  wire rsp_t rsp
);
  timeunit 1ns;
  timeprecision 1ps;
  rsp_t lastRsp;
  logic gotRsp;

  initial
  begin
    reqValid = 1'b0;
    req = '0;
  end

  // One 16-bit word per request; commands are sent as given (upper case
  // normally, lower case only when a scenario asks for a refusal)
  task automatic send(input logic [7:0] cmd, input logic [15:0] addr,
                      input logic [15:0] data);
    int n;
    @(posedge mclk);
    #1;
    reqValid = 1'b1;
    req = '{cmd: cmd, addr: addr, data: data};
    @(posedge mclk);
    #1;
    reqValid = 1'b0;
    req = ~req;
    gotRsp = 1'b0;
    for (n = 0; n < 4 && !gotRsp; n++)
    begin
      if (rspValid === 1'b1)
        gotRsp = 1'b1;
      else
      begin
        @(posedge mclk);
        #1;
      end
    end
    lastRsp = gotRsp ? rsp : 'x;
  endtask
endmodule

// [dv/test_drive_param_access_checker.sv]
// Bench for the parameter access checker, driving it through the master model
// Assumes the map constants of drive_param_regs.svh
`include "drive_param_regs.svh"
module test_drive_param_access_checker
  import drive_param_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'b0, nrst = 1'b0, reqValid, rspValid, netErrorEvent = 1'b0;
  logic stopReq, fwdReq, revReq, estopReq, faultResetPulse;
  logic [15:0] speedSetpoint, rampUpTime, rampDownTime;
  logic [1:0] cmdSource = 2'b10;
  logic [4:0] freqSource = 5'd29;
  req_t req;
  rsp_t rsp;
  drv_status_t drvStatus = '0;
  meas_t meas = '{16'h0123, 16'h0456, 16'h0789, 16'h0abc, 16'h0def};
  int failures = 0, checks = 0;

  always #2 mclk = ~mclk;

  drive_param_access_checker drive_param_access_checker_inst (.mclk(mclk), .nrst(nrst),
    .reqValid(reqValid), .req(req), .rspValid(rspValid), .rsp(rsp), .drvStatus(drvStatus),
    .meas(meas), .cmdSource(cmdSource), .freqSource(freqSource),
    .netErrorEvent(netErrorEvent), .stopReq(stopReq), .fwdReq(fwdReq), .revReq(revReq),
    .estopReq(estopReq), .faultResetPulse(faultResetPulse), .speedSetpoint(speedSetpoint),
    .rampUpTime(rampUpTime), .rampDownTime(rampDownTime));

  link_master_model link_master_model_inst (.mclk(mclk), .reqValid(reqValid), .req(req),
    .rspValid(rspValid), .rsp(rsp));

  task automatic chk16(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp)
    begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk1(input string what, input logic exp, input logic got);
    chk16(what, {15'h0, exp}, {15'h0, got});
  endtask

  // Send one request, then judge the reply kind and its code or data word
  task automatic ask(input logic [7:0] c, input logic [15:0] a, input logic [15:0] d,
                     input logic [15:0] err, input logic [15:0] exp, input logic [15:0] msk);
    rsp_t r;
    link_master_model_inst.send(c, a, d);
    r = link_master_model_inst.lastRsp;
    chk16("reply ctrl", {8'h0, (err === `ERR_NONE) ? `CH_ACK : `CH_NAK}, {8'h0, r.ctrl});
    chk16("reply cmd echo", {8'h0, c}, {8'h0, r.cmd});
    chk16("reply err", err, r.err);
    if (err === `ERR_NONE)
      chk16("reply data", exp & msk, r.data & msk);
  endtask

  task automatic t_map;
    ask(`CH_READ, `OFS_FWVER, 16'h0, `ERR_NONE, 16'h0100, 16'hffff);
    ask(`CH_READ, `OFS_CURRENT, 16'h0, `ERR_NONE, 16'h0123, 16'hffff);
    ask(`CH_READ, `OFS_POWER, 16'h0, `ERR_NONE, 16'h0def, 16'hffff);
    ask(`CH_READ, 16'h0004, 16'h0, `ERR_ADDR, 16'h0, 16'h0);
    ask(`CH_READ, 16'h000f, 16'h0, `ERR_ADDR, 16'h0, 16'h0);
    ask(`CH_MONREG, 16'h0, 16'h0, `ERR_NONE, 16'h0, 16'hffff);
    ask(`CH_MONACT, 16'h0, 16'h0, `ERR_NONE, 16'h0, 16'hffff);
    $display("test map done");
  endtask

  task automatic t_refusals;
    ask(8'h5a, `OFS_FWVER, 16'h0, `ERR_FUNC, 16'h0, 16'h0);
    ask(8'h72, `OFS_FWVER, 16'h0, `ERR_FUNC, 16'h0, 16'h0);
    ask(8'h77, 16'h0004, 16'hffff, `ERR_FUNC, 16'h0, 16'h0);
    ask(`CH_WRITE, 16'h0004, 16'hffff, `ERR_ADDR, 16'h0, 16'h0);
    ask(`CH_WRITE, `OFS_MODEL, 16'hffff, `ERR_WMODE, 16'h0, 16'h0);
    ask(`CH_WRITE, `OFS_SPEED, 16'h2ee1, `ERR_VALUE, 16'h0, 16'h0);
    chk16("speed kept", 16'h0000, speedSetpoint);
    ask(`CH_WRITE, `OFS_SPEED, 16'h2ee0, `ERR_NONE, 16'h0000, 16'hffff);
    chk16("speed set", 16'h2ee0, speedSetpoint);
    drvStatus.fwd = 1'b1;
    ask(`CH_WRITE, `OFS_RAMPUP, 16'h0064, `ERR_WMODE, 16'h0, 16'h0);
    ask(`CH_WRITE, `OFS_RAMPDN, 16'hffff, `ERR_WMODE, 16'h0, 16'h0);
    drvStatus.fwd = 1'b0;
    ask(`CH_WRITE, `OFS_RAMPDN, 16'h1771, `ERR_VALUE, 16'h0, 16'h0);
    ask(`CH_WRITE, `OFS_RAMPUP, 16'h1770, `ERR_NONE, 16'h0032, 16'hffff);
    chk16("ramp up", 16'h1770, rampUpTime);
    chk16("ramp down kept", 16'h0032, rampDownTime);
    $display("test refusals done");
  endtask

  task automatic t_command;
    ask(`CH_WRITE, `OFS_CMDWORD, 16'h0006, `ERR_VALUE, 16'h0, 16'h0);
    ask(`CH_WRITE, `OFS_CMDWORD, 16'h0002, `ERR_NONE, 16'h0, 16'h0);
    chk1("fwd", 1'b1, fwdReq);
    chk1("rev", 1'b0, revReq);
    ask(`CH_WRITE, `OFS_CMDWORD, 16'h0005, `ERR_NONE, 16'h0, 16'h0);
    chk1("stop", 1'b1, stopReq);
    chk1("rev on", 1'b1, revReq);
    chk1("fwd off", 1'b0, fwdReq);
    ask(`CH_WRITE, `OFS_CMDWORD, 16'h0010, `ERR_NONE, 16'h0, 16'h0);
    chk1("estop", 1'b1, estopReq);
    ask(`CH_WRITE, `OFS_CMDWORD, 16'h0020, `ERR_NONE, 16'h0, 16'h0);
    chk16("bit5 idle", 16'h0000,
          {11'h000, stopReq, fwdReq, revReq, estopReq, faultResetPulse});
    ask(`CH_WRITE, `OFS_CMDWORD, 16'h0008, `ERR_NONE, 16'h0, 16'h0);
    chk1("reset edge", 1'b1, faultResetPulse);
    @(posedge mclk);
    #1;
    chk1("reset one cycle", 1'b0, faultResetPulse);
    ask(`CH_WRITE, `OFS_CMDWORD, 16'h0008, `ERR_NONE, 16'h0, 16'h0);
    chk1("reset held", 1'b0, faultResetPulse);
    ask(`CH_READ, `OFS_CMDWORD, 16'h0, `ERR_NONE, 16'h1d80, 16'h9fc0);
    netErrorEvent = 1'b1;
    @(posedge mclk);
    #1;
    netErrorEvent = 1'b0;
    cmdSource = 2'b01;
    freqSource = 5'd17;
    ask(`CH_READ, `OFS_CMDWORD, 16'h0, `ERR_NONE, 16'h9140, 16'h9fc0);
    $display("test command done");
  endtask

  task automatic t_status;
    drvStatus = '{fwd: 1'b1, rev: 1'b0, trip: 1'b1, accel: 1'b0, decel: 1'b1};
    ask(`CH_READ, `OFS_STATUS, 16'h0, `ERR_NONE, 16'h002a, 16'h003e);
    drvStatus = '{fwd: 1'b0, rev: 1'b1, trip: 1'b0, accel: 1'b1, decel: 1'b0};
    ask(`CH_READ, `OFS_STATUS, 16'h0, `ERR_NONE, 16'h0014, 16'h003e);
    drvStatus = '0;
    ask(`CH_READ, `OFS_STATUS, 16'h0, `ERR_NONE, 16'h0001, 16'h003f);
    ask(`CH_WRITE, `OFS_STATUS, 16'h0, `ERR_WMODE, 16'h0, 16'h0);
    $display("test status done");
  endtask

  task automatic complete_run;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  initial
  begin
    repeat (4) @(posedge mclk);
    #1;
    nrst = 1'b1;
    t_map();
    t_refusals();
    t_command();
    t_status();
    complete_run();
  end

  // Roughly 30 requests of a few clocks each; a generous margin on top
  initial
  begin
    #20000;
    failures++;
    complete_run();
  end
endmodule
